// file: include/asr_cfg.svh
// constants of the converter serial readout and span configuration block
// assumes inclusion by bare name from design files
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_CH_NUM 8
`define ASR_RES_W 16
`define ASR_CODE_W 3
`define ASR_CFG_W 24
`define ASR_WORD_W 24
`define ASR_FRAME_W 192
`define ASR_LAST_BIT 8'hbf
`define ASR_SPAN_RESET 24'hffffff
`define ASR_CODE_OFF 3'h0
`define ASR_RX_FULL 5'h18
// per channel word: result [23:8], channel index [7:5], span code [4:2], zero [1:0]
`define ASR_F_RES_LSB 8
`define ASR_F_IDX_LSB 5
`define ASR_F_SPAN_LSB 2
`endif

// file: include/asr_pkg.sv
// types of the converter serial readout and span configuration block
// assumes asr_cfg.svh on the include path
`default_nettype none
`include "asr_cfg.svh"
package asr_pkg;
   typedef logic [`ASR_CODE_W-1:0] asr_span_t;
   typedef logic [`ASR_RES_W-1:0] asr_result_t;
   typedef logic [`ASR_FRAME_W-1:0] asr_frame_t;
endpackage : asr_pkg
`default_nettype wire

// file: rtl/asr_serial_readout.sv
// serial readout of eight converter results and intake of the span word
// assumes pins arrive unsynchronised; converter results come from core_clk logic
`default_nettype none
`include "asr_cfg.svh"

// Notes on behaviour
// R01 - cmos lanes advance one bit per rising edge
// R02 - cmos config input sampled on rising edges
// R03 - host captures cmos data on rising edges
// R04 - shift clock may idle high or low
// R05 - cmos echo clock toggles each rising edge
// R06 - cmos echo clock forced low when busy falls
// R07 - host may use echo ddr, else ignore
// R08 - host shifts in 24-bit span word
// R09 - constant high input gives span seven everywhere
// R10 - bus live only while select low
// R11 - lvds config sampled on both edges
// R12 - lvds host idles shift clock low
// R13 - lvds single lane both edges, channel zero first
// R14 - lvds echo copies received shift clock
// R15 - lvds mode keeps shared cmos lanes off
// R16 - terminations on only while select low
// R17 - word is eight concatenated 3-bit codes
// R18 - code zero disables channel, zero result
// R19 - code bit one selects bipolar range
// R20 - bipolar twos complement, unipolar straight binary
// R21 - busy high from start to finish
// R22 - mode pin strapped, fixed per board
// R23 - msb first, channel seven code on top
module asr_serial_readout
   import asr_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic lvds_mode_pin,
   input wire logic chip_select_n,
   input wire logic host_shift_clock,
   input wire logic config_serial_in,
   input wire logic conv_start,
   input wire logic conv_valid,
   input wire logic [`ASR_CH_NUM*`ASR_RES_W-1:0] conv_result,
   output logic conv_ready,
   output logic conv_busy,
   output logic [`ASR_CH_NUM-1:0] serial_out_lane,
   output logic [`ASR_CH_NUM-1:0] serial_out_lane_oe,
   output logic lvds_data_out,
   output logic lvds_data_oe,
   output logic echo_shift_clock,
   output logic echo_shift_clock_oe,
   output logic term_enable,
   output logic [`ASR_CFG_W-1:0] span_config
);
   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CNT_W = $clog2(BUF_DEPTH + 1);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic asr_result_t fmt_result(input asr_result_t raw, input asr_span_t code);
      if (code == `ASR_CODE_OFF) begin
         fmt_result = '0; // R18
      end else if (code[1]) begin
         fmt_result = {~raw[`ASR_RES_W-1], raw[`ASR_RES_W-2:0]}; // R19 R20
      end else begin
         fmt_result = raw; // R20
      end
   endfunction : fmt_result

   function automatic asr_frame_t build_frame(input logic [`ASR_CH_NUM*`ASR_RES_W-1:0] raw,
                                              input logic [`ASR_CFG_W-1:0] span);
      logic [`ASR_WORD_W-1:0] word;
      asr_span_t code;
      build_frame = '0;
      for (int c = 0; c < `ASR_CH_NUM; c++) begin
         code = span[c*`ASR_CODE_W +: `ASR_CODE_W]; // R17 R23
         word = '0;
         word[`ASR_F_RES_LSB +: `ASR_RES_W] = fmt_result(raw[c*`ASR_RES_W +: `ASR_RES_W], code);
         word[`ASR_F_IDX_LSB +: 3] = 3'(c);
         word[`ASR_F_SPAN_LSB +: `ASR_CODE_W] = code;
         // channel 0 sits in the top word so it leaves first
         build_frame[(`ASR_CH_NUM-1-c)*`ASR_WORD_W +: `ASR_WORD_W] = word;
      end
   endfunction : build_frame

   // bit for a lane at stream position pos; lanes rotate through channels
   function automatic logic frame_bit(input asr_frame_t f, input int lane, input logic [7:0] pos);
      int ch;
      int b;
      ch = (lane + int'(pos) / `ASR_WORD_W) % `ASR_CH_NUM;
      b = `ASR_WORD_W - 1 - int'(pos) % `ASR_WORD_W;
      frame_bit = f[(`ASR_CH_NUM-1-ch)*`ASR_WORD_W + b];
   endfunction : frame_bit

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic cs_prev;
   logic sck_prev;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pin_s1 <= 4'h1;
         pin_s2 <= 4'h1;
         cs_prev <= 1'b1;
         sck_prev <= 1'b0;
      end else begin
         pin_s1 <= {lvds_mode_pin, config_serial_in, host_shift_clock, chip_select_n};
         pin_s2 <= pin_s1;
         cs_prev <= pin_s2[0];
         sck_prev <= pin_s2[1];
      end
   end

   logic cs_n_s;
   logic sck_s;
   logic sdi_s;
   logic lvds;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic shift_edge;
   assign cs_n_s = pin_s2[0];
   assign sck_s = pin_s2[1];
   assign sdi_s = pin_s2[2];
   assign lvds = pin_s2[3]; // strap, never changes in use
   assign cs_fall = cs_prev && !cs_n_s;
   assign cs_rise = !cs_prev && cs_n_s;
   // edges only count while selected; comparing levels means either idle level is fine
   assign sck_rise = !cs_n_s && !cs_prev && sck_s && !sck_prev; // R04 R10
   assign sck_fall = !cs_n_s && !cs_prev && !sck_s && sck_prev;
   assign shift_edge = sck_rise || (lvds && sck_fall); // R11 R13

   // ----------------------------------------
   // conversion busy flag
   // ----------------------------------------
   logic push;
   assign push = conv_valid && conv_ready;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         conv_busy <= 1'b0;
      end else if (conv_start) begin
         conv_busy <= 1'b1; // R21
      end else if (push) begin
         conv_busy <= 1'b0; // R21
      end
   end

   // ----------------------------------------
   // two-entry result buffer
   // ----------------------------------------
   asr_frame_t buf_mem [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] buf_cnt;
   logic pop;
   logic [CNT_W-1:0] next_buf_cnt;
   // drained only at frame start, so a host that never selects stalls the converter
   assign pop = cs_fall && (buf_cnt != '0);
   assign next_buf_cnt = CNT_W'(buf_cnt + CNT_W'(push) - CNT_W'(pop));

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (int'(p) == BUF_DEPTH - 1) ? '0 : PTR_W'(p + 1'b1);
   endfunction : ptr_inc

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         buf_cnt <= '0;
         conv_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= ptr_inc(rd_ptr);
         end
         buf_cnt <= next_buf_cnt;
         conv_ready <= int'(next_buf_cnt) < BUF_DEPTH;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         buf_mem[wr_ptr] <= build_frame(conv_result, span_config);
      end
   end

   // ----------------------------------------
   // output stream
   // ----------------------------------------
   asr_frame_t frame;
   logic [7:0] bit_pos;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         frame <= '0;
         bit_pos <= '0;
      end else if (cs_fall) begin
         if (pop) begin
            frame <= buf_mem[rd_ptr];
         end
         bit_pos <= '0; // no fresh result: repeat the latest one
      end else if (shift_edge) begin
         bit_pos <= (bit_pos == `ASR_LAST_BIT) ? 8'h00 : 8'(bit_pos + 8'h01); // R01 R13
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         serial_out_lane <= '0;
         serial_out_lane_oe <= '0;
         lvds_data_out <= 1'b0;
         lvds_data_oe <= 1'b0;
      end else begin
         for (int l = 0; l < `ASR_CH_NUM; l++) begin
            serial_out_lane[l] <= frame_bit(frame, l, bit_pos); // R01
            serial_out_lane_oe[l] <= !cs_n_s && !lvds; // R10 R15
         end
         lvds_data_out <= frame_bit(frame, 0, bit_pos); // R13
         lvds_data_oe <= !cs_n_s && lvds; // R10
      end
   end

   // ----------------------------------------
   // echo clock and terminations
   // ----------------------------------------
   logic busy_fall;
   logic echo_state;
   assign busy_fall = conv_busy && push && !conv_start;

   // echo_state moves with bit_pos; the extra stage lines echo edges up with
   // the lane changes, which trail bit_pos by one register as well
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         echo_state <= 1'b0;
         echo_shift_clock <= 1'b0;
         echo_shift_clock_oe <= 1'b0;
         term_enable <= 1'b0;
      end else begin
         if (lvds) begin
            echo_state <= sck_s && !cs_n_s; // R14
         end else if (busy_fall) begin
            echo_state <= 1'b0; // R06
         end else if (sck_rise) begin
            echo_state <= !echo_state; // R05
         end
         echo_shift_clock <= echo_state; // R05 R14
         echo_shift_clock_oe <= !cs_n_s; // R10
         term_enable <= !cs_n_s && lvds; // R16
      end
   end

   // ----------------------------------------
   // span word intake
   // ----------------------------------------
   logic [`ASR_CFG_W-1:0] rx_word;
   logic [4:0] rx_cnt;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_word <= '0;
         rx_cnt <= '0;
         span_config <= `ASR_SPAN_RESET; // R09
      end else if (cs_fall) begin
         rx_cnt <= '0;
      end else if (cs_rise) begin
         if (rx_cnt == `ASR_RX_FULL) begin
            span_config <= rx_word; // R17 R23
         end
      end else if (shift_edge) begin
         rx_word <= {rx_word[`ASR_CFG_W-2:0], sdi_s}; // R02 R11 R23
         if (rx_cnt != `ASR_RX_FULL) begin
            rx_cnt <= 5'(rx_cnt + 5'h01);
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_lanes_off_deselect: assert property (@(posedge core_clk) disable iff (!resetn) // R10
      cs_n_s |=> (serial_out_lane_oe == '0) && !lvds_data_oe)
      else $error("outputs driven while deselected");

   a_lvds_lanes_hiz: assert property (@(posedge core_clk) disable iff (!resetn) // R15
      lvds |=> !serial_out_lane_oe[0] && !serial_out_lane_oe[`ASR_CH_NUM-1])
      else $error("shared cmos lanes driven in lvds mode");

   a_term_follows_cs: assert property (@(posedge core_clk) disable iff (!resetn) // R16
      ##1 term_enable == ($past(!cs_n_s) && $past(lvds)))
      else $error("termination not following select");

   a_echo_toggles: assert property (@(posedge core_clk) disable iff (!resetn) // R05
      (!lvds && sck_rise && !busy_fall) |=> echo_state != $past(echo_state))
      else $error("cmos echo clock missed a toggle");

   a_echo_low_busy: assert property (@(posedge core_clk) disable iff (!resetn) // R06
      (!lvds && $fell(conv_busy)) |=> !echo_shift_clock)
      else $error("echo clock not low after busy fell");

   a_busy_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R21
      (conv_start && !push) |=> conv_busy ##1 (conv_busy || $past(push)))
      else $error("busy not held through conversion");

   a_cmos_shift: assert property (@(posedge core_clk) disable iff (!resetn) // R01
      (sck_rise && bit_pos != `ASR_LAST_BIT) |=> bit_pos == $past(bit_pos) + 8'h01)
      else $error("stream position did not advance");

   a_lvds_both_edges: assert property (@(posedge core_clk) disable iff (!resetn) // R11
      (lvds && sck_fall && bit_pos != `ASR_LAST_BIT) |=> bit_pos == $past(bit_pos) + 8'h01)
      else $error("lvds falling edge did not shift");

   a_span_apply: assert property (@(posedge core_clk) disable iff (!resetn) // R09
      (cs_rise && rx_cnt == `ASR_RX_FULL) |=> span_config == $past(rx_word))
      else $error("full span word not applied");

   a_stall_full: assert property (@(posedge core_clk) disable iff (!resetn)
      (int'(buf_cnt) == BUF_DEPTH) |-> !conv_ready)
      else $error("buffer accepts while full");

   a_lvds_echo_copy: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      (lvds && !cs_n_s) |-> ##2 echo_shift_clock == $past(sck_s, 2))
      else $error("lvds echo not a copy of the shift clock");

   a_busy_start: assert property (@(posedge core_clk) disable iff (!resetn) // R21
      conv_start |=> conv_busy)
      else $error("busy did not rise at conversion start");

   a_span_short: assert property (@(posedge core_clk) disable iff (!resetn) // R17
      (cs_rise && rx_cnt != `ASR_RX_FULL) |=> span_config == $past(span_config))
      else $error("short span word was applied");

   a_lanes_on_select: assert property (@(posedge core_clk) disable iff (!resetn) // R10
      (!cs_n_s && !lvds) |=> (serial_out_lane_oe == '1) && !lvds_data_oe)
      else $error("cmos lanes not driven while selected");
endmodule : asr_serial_readout
`default_nettype wire

// file: sim/asr_host_model.sv
// host model: drives select, shift clock and span word, captures one data line
// assumes the bench routes the lane under test to data_in and calls xfer
`default_nettype none
module asr_host_model (
   output var logic chip_select_n,
   output var logic host_shift_clock,
   output var logic config_serial_in,
   input wire logic data_in,
   input wire logic echo_in,
   input wire logic [10:0] watch
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      chip_select_n = 1'b1;
      host_shift_clock = 1'b0;
      config_serial_in = 1'b1;
   end

   // ----------------------------------------
   // one transfer, 20 ns ticks, 160 ns period
   // ----------------------------------------
   // data is taken 140 ns after an edge: the pins pass a synchroniser,
   // so the bit launched by that edge is late but settled by then
   task automatic xfer(input int nbits, input logic lvds, input logic [23:0] cfg,
                       output logic [191:0] got, output logic [10:0] seen, output logic echo);
      int k;
      int s;
      int t;
      k = 0;
      s = 1;
      t = 0;
      #7;
      chip_select_n = 1'b0;
      #200;
      got = {191'h0, data_in};
      seen = watch;
      while (s < nbits || k < nbits || host_shift_clock) begin
         #20;
         t++;
         if (t % 4 == 2 && k < nbits && (lvds || t % 8 == 2))
            config_serial_in = cfg[23 - (k % 24)];
         if (t % 4 == 0 && (k < nbits || host_shift_clock)) begin
            host_shift_clock = !host_shift_clock;
            if (lvds || host_shift_clock)
               k++;
         end
         if (t % 4 == 3 && t >= 11 && s < nbits && (lvds || t % 8 == 3)) begin
            got = {got[190:0], data_in};
            s++;
         end
      end
      #100;
      echo = echo_in;
      chip_select_n = 1'b1;
      // released line shows no stale value
      config_serial_in = !config_serial_in;
   endtask : xfer
endmodule : asr_host_model
`default_nettype wire

// file: sim/test_asr_serial_readout.sv
// testbench of the serial readout block with a host model on the pins
// assumes the design package and header on the include path
`default_nettype none
module test_asr_serial_readout;
   import asr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] CFG = 24'hfac688;
   localparam logic [23:0] CFG2 = 24'h2d1b57;
   logic core_clk, resetn, lvds_mode_pin, conv_start, conv_valid, conv_ready, conv_busy;
   logic chip_select_n, host_shift_clock, config_serial_in, host_data;
   logic lvds_data_out, lvds_data_oe, echo_shift_clock, echo_shift_clock_oe, term_enable, echo;
   logic [127:0] conv_result;
   logic [7:0] serial_out_lane, serial_out_lane_oe;
   logic [23:0] span_config;
   logic [10:0] pins_on, seen;
   logic [191:0] got;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   // a released line shows the inverse, so a missing enable spoils the data
   assign host_data = lvds_mode_pin ? (lvds_data_oe ? lvds_data_out : !lvds_data_out)
      : (serial_out_lane_oe[0] ? serial_out_lane[0] : !serial_out_lane[0]);
   assign pins_on = {serial_out_lane_oe, lvds_data_oe, echo_shift_clock_oe, term_enable};

   asr_serial_readout #(.BUF_DEPTH(2)) dut (.core_clk, .resetn, .lvds_mode_pin, .chip_select_n,
      .host_shift_clock, .config_serial_in, .conv_start, .conv_valid, .conv_result, .conv_ready, .conv_busy,
      .serial_out_lane, .serial_out_lane_oe, .lvds_data_out, .lvds_data_oe, .echo_shift_clock,
      .echo_shift_clock_oe, .term_enable, .span_config);
   asr_host_model host (.chip_select_n, .host_shift_clock, .config_serial_in, .data_in(host_data),
      .echo_in(echo_shift_clock), .watch(pins_on));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = !core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [191:0] g, input logic [191:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   function automatic logic [127:0] bus_of(input int set);
      logic [127:0] b;
      for (int c = 0; c < 8; c++)
         b[16*c +: 16] = 16'h9a5c ^ (16'(c) * 16'h2111) ^ (16'(set) * 16'h4e3d);
      return b;
   endfunction : bus_of

   function automatic logic [191:0] exp_frame(input int set, input logic [23:0] cfg);
      logic [127:0] b;
      logic [191:0] f;
      logic [2:0] code;
      logic [15:0] r;
      b = bus_of(set);
      for (int c = 0; c < 8; c++) begin
         code = cfg[3*c +: 3];
         r = b[16*c +: 16];
         if (code == 3'h0) r = 16'h0000;
         else if (code[1]) r = r ^ 16'h8000;
         f[191-24*c -: 24] = {r, 3'(c), code, 2'b00};
      end
      return f;
   endfunction : exp_frame

   task automatic push(input int set);
      int n;
      @(posedge core_clk);
      conv_start <= 1'b1;
      @(posedge core_clk);
      conv_start <= 1'b0;
      conv_valid <= 1'b1;
      conv_result <= bus_of(set);
      #1 check(conv_busy, 1'b1);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (conv_ready !== 1'b1 && n < 50);
      conv_valid <= 1'b0;
      #1 check(conv_busy, 1'b0);
   endtask : push

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check(span_config, 24'hffffff);
      check(pins_on, 11'h000);
   endtask : t_reset

   task automatic t_short_and_busy();
      host.xfer(1, 1'b0, 24'h0, got, seen, echo);
      check(echo, 1'b1);
      check(span_config, 24'hffffff);
      push(0);
      repeat (2) @(posedge core_clk);
      check(echo_shift_clock, 1'b0);
   endtask : t_short_and_busy

   task automatic t_span_word();
      host.xfer(24, 1'b0, CFG, got, seen, echo);
      check(got[23:0], exp_frame(0, 24'hffffff) >> 168);
      check(seen, 11'h7fa);
      repeat (6) @(posedge core_clk);
      check(span_config, CFG);
      check(pins_on, 11'h000);
   endtask : t_span_word

   task automatic t_buffer_cmos();
      push(1);
      push(2);
      repeat (3) @(posedge core_clk);
      check(conv_ready, 1'b0);
      host.xfer(192, 1'b0, CFG, got, seen, echo);
      check(got, exp_frame(1, CFG));
      check(conv_ready, 1'b1);
   endtask : t_buffer_cmos

   task automatic t_lvds();
      @(posedge core_clk);
      lvds_mode_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      host.xfer(192, 1'b1, CFG2, got, seen, echo);
      check(got, exp_frame(2, CFG));
      check(seen, 11'h007);
      check(echo, 1'b0);
      repeat (6) @(posedge core_clk);
      check(span_config, CFG2);
      check(pins_on, 11'h000);
   endtask : t_lvds

   initial begin
      resetn = 1'b0;
      lvds_mode_pin = 1'b0;
      conv_start = 1'b0;
      conv_valid = 1'b0;
      conv_result = 128'h0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_short_and_busy();
      t_span_word();
      t_buffer_cmos();
      t_lvds();
      tally_and_finish();
   end
endmodule : test_asr_serial_readout
`default_nettype wire
